// [design/rccs_regs.svh]
/*
  Constants of the reset and clock configuration strap block: register
  offsets, field positions, reset values and timing counts.
  Assumes a 50 MHz hclk and a 32-bit AHB-Lite register bus.
*/
// Function
// R1 - Strap low: regulator on, power-good waits threshold
// R2 - Internal reset is power-good AND reset pin
// R3 - Strap high: regulator off, Hi-Z, power-good high
// R4 - Regulator off: reset pin sole reset source
// R5 - Regulator level follows voltage-select bit
// R6 - Slow parts: software selects lower core voltage
// R7 - Clock strap low: oscillator drives system clock
// R8 - Clock strap high: external clock drives system
// R9 - Clock-source strap never changes while running
// R10 - Reset the device after changing any strap
// R11 - Sync reset release; capture straps during reset
`ifndef RCCS_REGS_SVH
`define RCCS_REGS_SVH

// Register byte offsets
`define RCCS_REG_CONTROL 12'h000
`define RCCS_REG_STATUS 12'h004
// Control fields
`define RCCS_CTL_VSEL_BIT 0
`define RCCS_CTL_RESET_VAL 32'h00000000
// Status fields
`define RCCS_ST_PGOOD_BIT 0
`define RCCS_ST_RESETN_BIT 1
`define RCCS_ST_REGDIS_BIT 2
`define RCCS_ST_CLKSEL_BIT 3
`define RCCS_ST_VSEL_BIT 4
// Reset release synchroniser depth
`define RCCS_SYNC_STAGES 2
// Power-good filter: 1 us of steady above-threshold level
`define RCCS_PGOOD_FILTER_NS 1000
`define RCCS_CLK_PERIOD_NS 20
`define RCCS_PGOOD_FILTER_CYC \
  ((`RCCS_PGOOD_FILTER_NS + `RCCS_CLK_PERIOD_NS - 1) / `RCCS_CLK_PERIOD_NS)
`define RCCS_CNT_W 8

`endif

// [design/rccs_pkg.sv]
/*
  Types of the reset and clock configuration strap block.
  Assumes the constants header is compiled alongside.
*/
package rccs_pkg;
  typedef enum logic [1:0] {
    RCCS_PG_OFF,
    RCCS_PG_WAIT,
    RCCS_PG_GOOD
  } rccs_pg_state_t;
  typedef enum logic {
    RCCS_CLK_OSC,
    RCCS_CLK_EXT
  } rccs_clk_src_t;
endpackage

// [design/rccs_sync.sv]
/*
  Reset-release synchroniser: asserts at once, releases after a fixed
  number of clock edges.
  Assumes the clock runs while reset is released.
*/
`timescale 1ns/10ps
`include "rccs_regs.svh"
module rccs_sync (
  // Clock and async reset in
  input wire logic clk,
  input wire logic arst_n,
  // Synchronised reset out
  output logic srst_n
);
  logic [`RCCS_SYNC_STAGES-1:0] stage;

  // Only the last stage is read; the first flop feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage <= '0;
    end else begin
      stage <= {stage[`RCCS_SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign srst_n = stage[`RCCS_SYNC_STAGES-1];
endmodule

// [design/rccs_top.sv]
/*
  Reset and clock configuration strap logic: regulator enable strap,
  power-good qualification, internal reset, clock source selection and
  an AHB-Lite slave holding the regulator voltage select.
  Assumes straps are static board ties and the reset pin is synchronous.
*/
`timescale 1ns/10ps
`include "rccs_regs.svh"
module rccs_top (
  // Bus clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Straps and reset pin
  input wire logic core_regulator_disable_strap,
  input wire logic clock_source_strap,
  input wire logic ext_reset_n,
  // Regulator monitor and control
  input wire logic regulator_above_threshold,
  output logic core_regulator_enable,
  output logic core_regulator_output_oe,
  output logic core_voltage_select,
  // Reset and clock selection outputs
  output logic power_good_a,
  output logic device_reset_n,
  output logic sysclk_from_external,
  output logic rtc_from_oscillator
);
  import rccs_pkg::*;

  logic reg_dis;
  rccs_clk_src_t clk_src;
  rccs_pg_state_t pg_state;
  rccs_pg_state_t next_pg_state;
  logic [`RCCS_CNT_W-1:0] pg_cnt;
  logic [`RCCS_CNT_W-1:0] next_pg_cnt;
  logic vsel;
  logic raw_reset_n;
  logic sync_reset_n;
  logic dp_write;
  logic [11:0] dp_addr;

  // Straps are sampled only while internal reset is held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg_dis <= 1'b0;
      clk_src <= RCCS_CLK_OSC;
    end else if (!device_reset_n) begin
      reg_dis <= core_regulator_disable_strap; // R11
      clk_src <= rccs_clk_src_t'(clock_source_strap); // R11
    end
  end

  // Power-good qualifier: threshold must hold for the filter time
  wire pg_cnt_done = (pg_cnt == `RCCS_CNT_W'(`RCCS_PGOOD_FILTER_CYC - 1));
  always_comb begin
    next_pg_state = pg_state;
    next_pg_cnt = pg_cnt;
    case (pg_state)
      RCCS_PG_OFF: begin
        next_pg_cnt = '0;
        if (reg_dis) begin
          next_pg_state = RCCS_PG_GOOD; // R3
        end else begin
          next_pg_state = RCCS_PG_WAIT; // R1
        end
      end
      RCCS_PG_WAIT: begin
        if (reg_dis) begin
          next_pg_state = RCCS_PG_GOOD; // R3
        end else if (!regulator_above_threshold) begin
          next_pg_cnt = '0;
        end else if (pg_cnt_done) begin
          next_pg_state = RCCS_PG_GOOD; // R1
        end else begin
          next_pg_cnt = pg_cnt + `RCCS_CNT_W'(1);
        end
      end
      RCCS_PG_GOOD: begin
        if (!reg_dis && !regulator_above_threshold) begin
          next_pg_state = RCCS_PG_WAIT; // R1
          next_pg_cnt = '0;
        end
      end
      default: begin
        next_pg_state = RCCS_PG_OFF;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pg_state <= RCCS_PG_OFF;
      pg_cnt <= '0;
    end else begin
      pg_state <= next_pg_state;
      pg_cnt <= next_pg_cnt;
    end
  end

  // Internal reset: AND of power-good and pin, release synchronised
  assign raw_reset_n = hresetn & ext_reset_n & power_good_a; // R2 R4

  rccs_sync u_sync (
    .clk(hclk),
    .arst_n(raw_reset_n),
    .srst_n(sync_reset_n)
  );

  // AHB-Lite slave, zero wait states
  wire ahb_go = hsel & hready & htrans[1];
  wire ctl_hit = (haddr == `RCCS_REG_CONTROL);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr <= '0;
    end else begin
      dp_write <= ahb_go & hwrite & ctl_hit;
      dp_addr <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vsel <= 1'(`RCCS_CTL_RESET_VAL >> `RCCS_CTL_VSEL_BIT);
    end else if (dp_write) begin
      vsel <= hwdata[`RCCS_CTL_VSEL_BIT]; // R5 R6
    end
  end

  wire [31:0] status_word = (32'h00000001 & 32'(power_good_a))
    << `RCCS_ST_PGOOD_BIT
    | 32'(device_reset_n) << `RCCS_ST_RESETN_BIT
    | 32'(reg_dis) << `RCCS_ST_REGDIS_BIT
    | 32'(clk_src) << `RCCS_ST_CLKSEL_BIT
    | 32'(vsel) << `RCCS_ST_VSEL_BIT;
  wire [31:0] next_rdata = !(ahb_go & !hwrite) ? 32'h00000000 :
    ctl_hit ? 32'(vsel) << `RCCS_CTL_VSEL_BIT :
    (haddr == `RCCS_REG_STATUS) ? status_word : 32'h00000000;

  // Outputs all registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      core_regulator_enable <= 1'b0;
      core_regulator_output_oe <= 1'b0;
      core_voltage_select <= 1'b0;
      power_good_a <= 1'b0;
      device_reset_n <= 1'b0;
      sysclk_from_external <= 1'b0;
      rtc_from_oscillator <= 1'b1;
    end else begin
      hrdata <= next_rdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      core_regulator_enable <= !reg_dis; // R1 R3
      core_regulator_output_oe <= !reg_dis; // R3
      core_voltage_select <= vsel; // R5
      power_good_a <= (next_pg_state == RCCS_PG_GOOD); // R1 R3
      device_reset_n <= sync_reset_n; // R2 R11
      sysclk_from_external <= (clk_src == RCCS_CLK_EXT); // R7 R8
      rtc_from_oscillator <= 1'b1; // R7 R8
    end
  end

  // Straps assumed static while running; new levels need a reset
  wire unused_ok = |{hsize, dp_addr}; // R9 R10

  property p_pg_bypass;
    @(posedge hclk) disable iff (!hresetn)
      (reg_dis && pg_state != RCCS_PG_OFF) |=> power_good_a;
  endproperty
  a_pg_bypass: assert property (p_pg_bypass) // R3
    else $error("power good not forced high with regulator off");

  property p_pg_needs_level;
    @(posedge hclk) disable iff (!hresetn)
      (!reg_dis && !regulator_above_threshold) |=> !power_good_a;
  endproperty
  a_pg_needs_level: assert property (p_pg_needs_level) // R1
    else $error("power good high while regulator below threshold");

  property p_reset_and;
    @(posedge hclk) disable iff (!hresetn)
      (!ext_reset_n || !power_good_a) |=> !device_reset_n;
  endproperty
  a_reset_and: assert property (p_reset_and) // R2
    else $error("internal reset released with a source low");

  sequence s_sources_up;
    ext_reset_n && power_good_a;
  endsequence
  property p_reset_release;
    @(posedge hclk) disable iff (!hresetn)
      s_sources_up [*3] |=> device_reset_n;
  endproperty
  a_reset_release: assert property (p_reset_release) // R11
    else $error("internal reset not released after sync delay");

  property p_reg_hiz;
    @(posedge hclk) disable iff (!hresetn)
      reg_dis |=> !core_regulator_output_oe && !core_regulator_enable;
  endproperty
  a_reg_hiz: assert property (p_reg_hiz) // R3
    else $error("regulator output driven while disabled");

  property p_vsel_write;
    @(posedge hclk) disable iff (!hresetn)
      dp_write |=> ##1 core_voltage_select == $past(hwdata[0], 2);
  endproperty
  a_vsel_write: assert property (p_vsel_write) // R5
    else $error("voltage select does not follow control write");

  property p_clk_ext;
    @(posedge hclk) disable iff (!hresetn)
      clk_src == RCCS_CLK_EXT |=> sysclk_from_external;
  endproperty
  a_clk_ext: assert property (p_clk_ext) // R8
    else $error("external clock not selected");

  property p_clk_osc;
    @(posedge hclk) disable iff (!hresetn)
      clk_src == RCCS_CLK_OSC |=> !sysclk_from_external
        && rtc_from_oscillator;
  endproperty
  a_clk_osc: assert property (p_clk_osc) // R7
    else $error("oscillator not driving system clock");

  property p_strap_hold;
    @(posedge hclk) disable iff (!hresetn)
      device_reset_n |=> $stable(clk_src) && $stable(reg_dis);
  endproperty
  a_strap_hold: assert property (p_strap_hold) // R11
    else $error("strap capture changed outside reset");
endmodule

// [bench/rccs_board.sv]
/*
  Board-side model: strap ties, reset source and regulator monitor.
  Assumes the bench asks for strap changes only while reset is held.
*/
`timescale 1ns/10ps
module rccs_board (
  // Clock and bench requests
  input wire logic hclk,
  input wire logic want_reset_n,
  input wire logic want_regdis,
  input wire logic want_clksel,
  input wire logic supply_ok,
  // Regulator state from the device
  input wire logic core_regulator_enable,
  // Board pins toward the device
  output logic core_regulator_disable_strap,
  output logic clock_source_strap,
  output logic ext_reset_n,
  output logic regulator_above_threshold
);
  initial begin
    ext_reset_n = 1'b0;
    core_regulator_disable_strap = 1'b0;
    clock_source_strap = 1'b0;
    regulator_above_threshold = 1'b0;
  end
  always @(posedge hclk) begin
    ext_reset_n <= want_reset_n;
    // Straps move only under a held reset, never in operation
    if (!want_reset_n && !ext_reset_n) begin
      core_regulator_disable_strap <= want_regdis;
      clock_source_strap <= want_clksel;
    end
    // A disabled regulator floats, so the monitor never sees a level
    regulator_above_threshold <= supply_ok & core_regulator_enable;
  end
endmodule

// [bench/reset_clock_config_straps_bench.sv]
/*
  Self-checking bench of the strap block: power-up release, bus rows, then strap and reset pin cases.
  Assumes the board model in rccs_board.sv and a zero-wait slave.
*/
`timescale 1ns/10ps
module reset_clock_config_straps_bench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, regdis, clksel, rstn, above, en, oe, vsel, pg;
  logic drst_n, sys_ext, rtc_osc;
  logic w_rst_n = 1'b0, w_regdis = 1'b0, w_clksel = 1'b0, w_ok = 1'b1;
  int n_fail = 0, tests_run = 0, c;
  logic [76:0] rows [5] = '{{1'b1, 12'h000, 32'h1, 32'h1},
    {1'b0, 12'h000, 32'h0, 32'h1}, {1'b0, 12'h004, 32'h0, 32'h13},
    {1'b0, 12'h008, 32'h0, 32'h0}, {1'b1, 12'h000, 32'h0, 32'h0}};
  always #10 hclk = ~hclk;
  rccs_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .core_regulator_disable_strap(regdis), .clock_source_strap(clksel),
    .ext_reset_n(rstn), .regulator_above_threshold(above),
    .core_regulator_enable(en), .core_regulator_output_oe(oe),
    .core_voltage_select(vsel), .power_good_a(pg),
    .device_reset_n(drst_n), .sysclk_from_external(sys_ext),
    .rtc_from_oscillator(rtc_osc));
  rccs_board i_board (.hclk(hclk), .want_reset_n(w_rst_n),
    .want_regdis(w_regdis), .want_clksel(w_clksel), .supply_ok(w_ok),
    .core_regulator_enable(en), .core_regulator_disable_strap(regdis),
    .clock_source_strap(clksel), .ext_reset_n(rstn),
    .regulator_above_threshold(above));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_reset_release();
    c = 0;
    while (drst_n !== 1'b1 && c < 200) begin
      @(posedge hclk);
      c++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    w_rst_n <= 1'b1;
    wait_reset_release();
    // Release waits on the 50-cycle power-good filter
    chk(c >= 50 && c < 70, 1);
    chk({pg, en, oe, sys_ext, rtc_osc}, 5'b11101);
    $display("power-up test done");
    foreach (rows[i]) begin
      bus(rows[i][76], rows[i][75:64], rows[i][63:32]);
      if (!rows[i][76]) chk(rd, rows[i][31:0]);
      if (i == 0) begin
        // The select pin lags the stored bit by one more flop
        repeat (2) @(posedge hclk);
        chk(vsel, 1'b1);
      end
    end
    repeat (2) @(posedge hclk);
    chk(vsel, 1'b0);
    chk({hresp, hreadyout}, 2'b01);
    $display("register test done");
    @(posedge hclk);
    w_ok <= 1'b0;
    repeat (4) @(posedge hclk);
    chk({pg, drst_n}, 2'b00);
    w_ok <= 1'b1;
    w_rst_n <= 1'b0;
    w_regdis <= 1'b1;
    w_clksel <= 1'b1;
    repeat (6) @(posedge hclk);
    w_rst_n <= 1'b1;
    wait_reset_release();
    chk(c < 12, 1);
    chk({pg, en, oe, sys_ext, rtc_osc}, 5'b10011);
    bus(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0F);
    $display("strap test done");
    w_rst_n <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(drst_n, 1'b0);
    $display("reset pin test done");
    report_and_stop();
  end
endmodule
